//--- rtl/sbn_pkg.sv
`default_nettype none
package sbn_pkg;
  // Operation select
  typedef enum logic [1:0] {
    SBN_OP_IDLE = 2'b00,
    SBN_OP_SUBB = 2'b01,
    SBN_OP_SWAP = 2'b10
  } sbn_op_t;

  // Phase of the two-cycle instruction
  typedef enum logic [1:0] {
    SBN_ST_IDLE  = 2'b00,
    SBN_ST_WRITE = 2'b01
  } sbn_state_t;

  localparam int unsigned SBN_DATA_W     = 8;
  localparam int unsigned SBN_ADDR_W     = 12;
  localparam logic [7:0]  SBN_IDX_LIMIT  = 8'h5F;
  localparam logic [7:0]  SBN_ACC_SPLIT  = 8'h60;
  localparam logic [3:0]  SBN_ACC_HIBANK = 4'hF;
  localparam logic [7:0]  SBN_RST_BYTE   = 8'h00;
  localparam logic [11:0] SBN_RST_ADDR   = 12'h000;
  localparam int unsigned SBN_NIB_LO     = 0;
  localparam int unsigned SBN_NIB_HI     = 4;
  localparam int unsigned SBN_MSB        = 7;
  localparam bit          SBN_DEST_ACC   = 1'b0;
  localparam bit          SBN_DEST_FILE  = 1'b1;
endpackage
`default_nettype wire

//--- rtl/sbn_core_if.sv
`timescale 1ns/1ps
`default_nettype none
// Operands and results passed between the top and the arithmetic unit
interface sbn_core_if;
  import sbn_pkg::*;
  logic [7:0] file_val;
  logic [7:0] acc_val;
  logic       carry_in;
  sbn_op_t    op;
  logic [7:0] result;
  logic       neg;
  logic       ovf;
  logic       carry;
  logic       dcarry;
  logic       zero;
  modport top (output file_val, acc_val, carry_in, op,
               input result, neg, ovf, carry, dcarry, zero);
  modport alu (input file_val, acc_val, carry_in, op,
               output result, neg, ovf, carry, dcarry, zero);
endinterface
`default_nettype wire

//--- rtl/sbn_alu.sv
`timescale 1ns/1ps
`default_nettype none
module sbn_alu (
  sbn_core_if.alu bus
);
  import sbn_pkg::*;
  logic [8:0] full;
  logic [4:0] low;
  logic       bin;

  // Subtract with borrow as f + ~W + C, or nibble exchange
  always_comb begin
    bin  = bus.carry_in;
    full = {1'b0, bus.file_val} + {1'b0, ~bus.acc_val} + {8'h00, bin};
    low  = {1'b0, bus.file_val[3:0]} + {1'b0, ~bus.acc_val[3:0]}
           + {4'h0, bin};
    bus.ovf    = 1'b0;
    bus.carry  = 1'b0;
    bus.dcarry = 1'b0;
    case (bus.op)
      SBN_OP_SUBB: begin
        bus.result = full[7:0];
        bus.carry  = full[8];   // High means no borrow
        bus.dcarry = low[4];
        bus.ovf    = (bus.file_val[SBN_MSB] != bus.acc_val[SBN_MSB]) &&
                     (full[SBN_MSB] != bus.file_val[SBN_MSB]);
      end
      SBN_OP_SWAP: begin
        bus.result = {bus.file_val[SBN_NIB_LO +: 4],
                      bus.file_val[SBN_NIB_HI +: 4]};
      end
      default: begin
        bus.result = bus.file_val;
      end
    endcase
    bus.neg  = bus.result[SBN_MSB];
    bus.zero = (bus.result == SBN_RST_BYTE);
  end
endmodule
`default_nettype wire

//--- rtl/sbn_top.sv
`timescale 1ns/1ps
`default_nettype none
module sbn_top (
  input  wire logic           CORE_CLK,
  input  wire logic           RST_N,
  input  wire sbn_pkg::sbn_op_t OP_START,
  input  wire logic [7:0]     FILE_ADDR,
  input  wire logic           DEST_SEL,
  input  wire logic           BANK_ACCESS,
  input  wire logic           EXT_SET_EN,
  input  wire logic [3:0]     BANK_SELECT_POINTER,
  input  wire logic [11:0]    INDEX_BASE,
  output logic [11:0]         RD_ADDR,
  input  wire logic [7:0]     RD_DATA,
  output logic                WR_EN,
  output logic [11:0]         WR_ADDR,
  output logic [7:0]          WR_DATA,
  output logic [7:0]          ACC,
  output logic                FLAG_N,
  output logic                OVERFLOW_FLAG,
  output logic                FLAG_C,
  output logic                DIGIT_CARRY_FLAG,
  output logic                FLAG_Z,
  output logic                BUSY
);
  import sbn_pkg::*;

  sbn_core_if core ();
  sbn_alu u_alu (.bus(core));

  sbn_state_t state;
  sbn_state_t next_state;
  sbn_op_t    op;
  sbn_op_t    next_op;
  logic       dest;
  logic       next_dest;
  logic [11:0] addr;
  logic [11:0] next_addr;
  logic [7:0]  acc;
  logic [7:0]  next_acc;
  logic        fn, fov, fc, fdc, fz;
  logic        next_fn, next_fov, next_fc, next_fdc, next_fz;
  logic        wr_en, next_wr_en;
  logic [11:0] wr_addr, next_wr_addr;
  logic [7:0]  wr_data, next_wr_data;
  logic [11:0] eff_addr;

  // Effective address: indexed, access bank, or banked
  always_comb begin
    if (EXT_SET_EN && !BANK_ACCESS && FILE_ADDR <= SBN_IDX_LIMIT) begin
      eff_addr = INDEX_BASE + {4'h0, FILE_ADDR};
    end else if (!BANK_ACCESS) begin
      eff_addr = (FILE_ADDR < SBN_ACC_SPLIT) ? {4'h0, FILE_ADDR}
                 : {SBN_ACC_HIBANK, FILE_ADDR};
    end else begin
      eff_addr = {BANK_SELECT_POINTER, FILE_ADDR};
    end
  end

  // Read address follows the request in idle, the latch while busy
  assign RD_ADDR = (state == SBN_ST_IDLE) ? eff_addr : addr;

  // Operand hookup to the arithmetic unit
  assign core.file_val = RD_DATA;
  assign core.acc_val  = acc;
  assign core.carry_in = fc;
  assign core.op       = op;

  // Next-state: capture request, then write result, and flags for subtract only
  always_comb begin
    next_state   = state;
    next_op      = op;
    next_dest    = dest;
    next_addr    = addr;
    next_acc     = acc;
    next_fn      = fn;
    next_fov     = fov;
    next_fc      = fc;
    next_fdc     = fdc;
    next_fz      = fz;
    next_wr_en   = 1'b0;
    next_wr_addr = wr_addr;
    next_wr_data = wr_data;
    case (state)
      SBN_ST_IDLE: begin
        if (OP_START != SBN_OP_IDLE) begin
          next_state = SBN_ST_WRITE;
          next_op    = OP_START;
          next_dest  = DEST_SEL;
          next_addr  = eff_addr;
        end
      end
      SBN_ST_WRITE: begin
        next_state = SBN_ST_IDLE;
        next_op    = SBN_OP_IDLE;
        if (dest == SBN_DEST_ACC) begin
          next_acc = core.result;
        end else begin
          next_wr_en   = 1'b1;
          next_wr_addr = addr;
          next_wr_data = core.result;
        end
        if (op == SBN_OP_SUBB) begin
          next_fn  = core.neg;
          next_fov = core.ovf;
          next_fc  = core.carry;
          next_fdc = core.dcarry;
          next_fz  = core.zero;
        end
      end
      default: begin
        next_state = SBN_ST_IDLE;
      end
    endcase
  end

  // Registers
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      state   <= SBN_ST_IDLE;
      op      <= SBN_OP_IDLE;
      dest    <= SBN_DEST_FILE;
      addr    <= SBN_RST_ADDR;
      acc     <= SBN_RST_BYTE;
      fn      <= 1'b0;
      fov     <= 1'b0;
      fc      <= 1'b0;
      fdc     <= 1'b0;
      fz      <= 1'b0;
      wr_en   <= 1'b0;
      wr_addr <= SBN_RST_ADDR;
      wr_data <= SBN_RST_BYTE;
    end else begin
      state   <= next_state;
      op      <= next_op;
      dest    <= next_dest;
      addr    <= next_addr;
      acc     <= next_acc;
      fn      <= next_fn;
      fov     <= next_fov;
      fc      <= next_fc;
      fdc     <= next_fdc;
      fz      <= next_fz;
      wr_en   <= next_wr_en;
      wr_addr <= next_wr_addr;
      wr_data <= next_wr_data;
    end
  end

  // Registered results and flags to the pins
  assign ACC              = acc;
  assign FLAG_N           = fn;
  assign OVERFLOW_FLAG    = fov;
  assign FLAG_C           = fc;
  assign DIGIT_CARRY_FLAG = fdc;
  assign FLAG_Z           = fz;
  assign WR_EN            = wr_en;
  assign WR_ADDR          = wr_addr;
  assign WR_DATA          = wr_data;
  assign BUSY             = (state != SBN_ST_IDLE);

  // Checks
  property p_subb_result;
    @(posedge CORE_CLK) disable iff (!RST_N)
    (state == SBN_ST_WRITE && op == SBN_OP_SUBB && dest == SBN_DEST_ACC)
    |=> (acc == $past(RD_DATA) - $past(acc) - {7'h00, !$past(fc)});
  endproperty
  a_subb_result: assert property (p_subb_result)
    else $error("subtract result wrong");

  property p_borrow;
    @(posedge CORE_CLK) disable iff (!RST_N)
    (state == SBN_ST_WRITE && op == SBN_OP_SUBB)
    |=> (fc == ({1'b0, $past(RD_DATA)} >=
                {1'b0, $past(acc)} + {8'h00, !$past(fc)}));
  endproperty
  a_borrow: assert property (p_borrow)
    else $error("carry not inverse of borrow");

  property p_digit_carry;
    @(posedge CORE_CLK) disable iff (!RST_N)
    (state == SBN_ST_WRITE && op == SBN_OP_SUBB)
    |=> (fdc == ({1'b0, $past(RD_DATA[3:0])} >=
                 {1'b0, $past(acc[3:0])} + {4'h0, !$past(fc)}));
  endproperty
  a_digit_carry: assert property (p_digit_carry)
    else $error("digit carry wrong");

  property p_zero;
    @(posedge CORE_CLK) disable iff (!RST_N)
    (state == SBN_ST_WRITE && op == SBN_OP_SUBB)
    |=> (fz == (($past(RD_DATA) - $past(acc) - {7'h00, !$past(fc)})
                == 8'h00));
  endproperty
  a_zero: assert property (p_zero)
    else $error("zero flag wrong");

  property p_dest_file;
    @(posedge CORE_CLK) disable iff (!RST_N)
    (state == SBN_ST_WRITE && dest == SBN_DEST_FILE)
    |=> (wr_en && wr_addr == $past(addr) && acc == $past(acc));
  endproperty
  a_dest_file: assert property (p_dest_file)
    else $error("file destination not written");

  property p_dest_acc;
    @(posedge CORE_CLK) disable iff (!RST_N)
    (state == SBN_ST_WRITE && dest == SBN_DEST_ACC) |=> !wr_en;
  endproperty
  a_dest_acc: assert property (p_dest_acc)
    else $error("file written for accumulator destination");

  property p_access_bank;
    @(posedge CORE_CLK) disable iff (!RST_N)
    (state == SBN_ST_IDLE && !BANK_ACCESS && !EXT_SET_EN
     && FILE_ADDR < SBN_ACC_SPLIT) |-> RD_ADDR[11:8] == 4'h0;
  endproperty
  a_access_bank: assert property (p_access_bank)
    else $error("access bank low half wrong");

  property p_indexed;
    @(posedge CORE_CLK) disable iff (!RST_N)
    (state == SBN_ST_IDLE && EXT_SET_EN && !BANK_ACCESS
     && FILE_ADDR <= SBN_IDX_LIMIT)
    |-> RD_ADDR == INDEX_BASE + {4'h0, FILE_ADDR};
  endproperty
  a_indexed: assert property (p_indexed)
    else $error("indexed address wrong");

  property p_swap;
    @(posedge CORE_CLK) disable iff (!RST_N)
    (state == SBN_ST_WRITE && op == SBN_OP_SWAP)
    |=> ({fn, fov, fc, fdc, fz} == $past({fn, fov, fc, fdc, fz}))
        && (wr_en ? wr_data == {$past(RD_DATA[3:0]), $past(RD_DATA[7:4])}
            : acc == {$past(RD_DATA[3:0]), $past(RD_DATA[7:4])});
  endproperty
  a_swap: assert property (p_swap)
    else $error("nibble swap wrong");
endmodule
`default_nettype wire

//--- bench/test_subtract_borrow_nibble_swap_alu.sv
`timescale 1ns/1ps
`default_nettype none
module test_subtract_borrow_nibble_swap_alu;
  import sbn_pkg::*;
  logic        CORE_CLK = 1'b0;
  logic        RST_N = 1'b0;
  sbn_op_t     OP_START = SBN_OP_IDLE;
  logic [7:0]  FILE_ADDR = 8'h00;
  logic        DEST_SEL = 1'b0;
  logic        BANK_ACCESS = 1'b0;
  logic        EXT_SET_EN = 1'b0;
  logic [3:0]  BANK_SELECT_POINTER = 4'h0;
  logic [11:0] INDEX_BASE = 12'h000;
  wire  [11:0] RD_ADDR;
  wire  [7:0]  RD_DATA;
  wire         WR_EN;
  wire  [11:0] WR_ADDR;
  wire  [7:0]  WR_DATA;
  wire  [7:0]  ACC;
  wire         FLAG_N;
  wire         OVERFLOW_FLAG;
  wire         FLAG_C;
  wire         DIGIT_CARRY_FLAG;
  wire         FLAG_Z;
  wire         BUSY;
  logic [7:0]  mem [0:4095];
  logic [7:0]  w_exp;
  logic [4:0]  fl_exp;
  logic [31:0] rnd;
  integer      seed = 63;
  integer      num_errors = 0;
  integer      tests_run = 0;

  sbn_top dut (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .OP_START(OP_START),
    .FILE_ADDR(FILE_ADDR), .DEST_SEL(DEST_SEL), .BANK_ACCESS(BANK_ACCESS),
    .EXT_SET_EN(EXT_SET_EN), .BANK_SELECT_POINTER(BANK_SELECT_POINTER),
    .INDEX_BASE(INDEX_BASE), .RD_ADDR(RD_ADDR), .RD_DATA(RD_DATA),
    .WR_EN(WR_EN), .WR_ADDR(WR_ADDR), .WR_DATA(WR_DATA), .ACC(ACC),
    .FLAG_N(FLAG_N), .OVERFLOW_FLAG(OVERFLOW_FLAG), .FLAG_C(FLAG_C),
    .DIGIT_CARRY_FLAG(DIGIT_CARRY_FLAG), .FLAG_Z(FLAG_Z), .BUSY(BUSY));

  // Clock and file memory with same-cycle read
  always #25 CORE_CLK = ~CORE_CLK;
  assign RD_DATA = mem[RD_ADDR];
  always @(posedge CORE_CLK) begin
    if (WR_EN === 1'b1) begin
      mem[WR_ADDR] <= WR_DATA;
    end
  end

  // Effective operand address
  function automatic logic [11:0] eff(logic [7:0] f, logic a, logic x);
    if (a) return {BANK_SELECT_POINTER, f};
    if (x && f <= 8'h5F) return INDEX_BASE + {4'h0, f};
    return {(f < 8'h60) ? 4'h0 : 4'hF, f};
  endfunction

  // Five flags, negative first, above the 8-bit difference
  function automatic logic [12:0] subb(logic [7:0] f, logic [7:0] w,
                                       logic c);
    logic [8:0] r;
    logic [4:0] lo;
    r = {1'b0, f} - {1'b0, w} - {8'h00, ~c};
    lo = {1'b0, f[3:0]} - {1'b0, w[3:0]} - {4'h0, ~c};
    return {r[7], (f[7] != w[7]) && (r[7] != f[7]), ~r[8], ~lo[4],
            r[7:0] == 8'h00, r[7:0]};
  endfunction

  task automatic check(string nm, logic [11:0] seen, logic [11:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic give_verdict;
    $display("tests_run=%0d num_errors=%0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // One operation; while busy, a swap request at the inverted address is driven on the inputs and refused
  task automatic do_op(sbn_op_t op, logic [7:0] f, logic d, logic a,
                       logic x);
    logic [11:0] ad;
    logic [7:0]  r;
    logic [12:0] s;
    OP_START = op;
    FILE_ADDR = f;
    DEST_SEL = d;
    BANK_ACCESS = a;
    EXT_SET_EN = x;
    ad = eff(f, a, x);
    @(posedge CORE_CLK);
    #1;
    check("BUSY", BUSY, 1'b1);
    check("RD_ADDR", RD_ADDR, ad);
    r = {mem[ad][3:0], mem[ad][7:4]};
    if (op == SBN_OP_SUBB) begin
      s = subb(mem[ad], w_exp, fl_exp[2]);
      r = s[7:0];
      fl_exp = s[12:8];
    end
    OP_START = SBN_OP_SWAP;
    FILE_ADDR = ~f;
    @(posedge CORE_CLK);
    #1;
    if (d) begin
      check("WR_EN", WR_EN, 1'b1);
      check("WR_ADDR", WR_ADDR, ad);
      check("WR_DATA", WR_DATA, r);
    end else begin
      w_exp = r;
      check("WR_EN", WR_EN, 1'b0);
    end
    check("ACC", ACC, w_exp);
    check("FLAGS", {FLAG_N, OVERFLOW_FLAG, FLAG_C, DIGIT_CARRY_FLAG,
                    FLAG_Z}, fl_exp);
  endtask

  // Hang guard
  initial begin
    repeat (50000) @(posedge CORE_CLK);
    num_errors++;
    give_verdict();
  end

  // Reset, corner addresses, then random back-to-back operations
  initial begin
    for (int i = 0; i < 4096; i++) mem[i] = 8'($random(seed));
    repeat (6) @(posedge CORE_CLK);
    #1;
    RST_N = 1'b1;
    w_exp = 8'h00;
    fl_exp = 5'h00;
    check("ACC", ACC, 8'h00);
    check("FLAGS", {FLAG_N, OVERFLOW_FLAG, FLAG_C, DIGIT_CARRY_FLAG,
                    FLAG_Z}, 5'h00);
    INDEX_BASE = 12'h3A0;
    BANK_SELECT_POINTER = 4'h7;
    do_op(SBN_OP_SWAP, 8'h5F, 1'b0, 1'b0, 1'b1);
    do_op(SBN_OP_SUBB, 8'h60, 1'b1, 1'b0, 1'b1);
    do_op(SBN_OP_SUBB, 8'hFF, 1'b0, 1'b1, 1'b0);
    do_op(SBN_OP_SUBB, 8'h00, 1'b1, 1'b0, 1'b0);
    for (int i = 0; i < 400; i++) begin
      rnd = $random(seed);
      BANK_SELECT_POINTER = rnd[31:28];
      INDEX_BASE = rnd[27:16];
      do_op(rnd[0] ? SBN_OP_SUBB : SBN_OP_SWAP, rnd[15:8], rnd[1],
            rnd[2], rnd[3]);
    end
    OP_START = SBN_OP_IDLE;
    repeat (2) @(posedge CORE_CLK);
    #1;
    check("BUSY", BUSY, 1'b0);
    give_verdict();
  end
endmodule
`default_nettype wire
